// File: bench/tpr_framer.sv
// far-end framer model: serial clock, frame sync and receive data
`timescale 1ns/100ps
module tpr_framer (
  // link outputs
  output logic sclk,
  output logic fsync,
  output logic sdata
);
  initial
  begin
    sclk = 1'b0;
    fsync = 1'b0;
    sdata = 1'b1;
  end

  // one shared clock and sync
  // clock stands still between bursts; released data shows the inverse level
  task automatic send_frames(input logic [7:0] b, input int n);
    int f;
    int i;
    fsync = 1'b0;
    #80 sclk = 1'b1;
    #80 sclk = 1'b0;
    for (f = 0; f < n; f++)
    begin
      for (i = 7; i >= 0; i--)
      begin
        fsync = (i == 7);
        sdata = b[i];
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
      end
    end
    fsync = 1'b0;
    sdata = ~sdata;
  endtask : send_frames
endmodule : tpr_framer

// File: bench/tpr_port_ctl_test.sv
// self-checking bench of the port reset, emulation and loopback block
`timescale 1ns/100ps
module tpr_port_ctl_test;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} tpr_row_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic sclk;
  logic fsync;
  logic sdata;
  logic pin;
  logic pin_oe_n;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] tx_byte = 8'h3C;
  logic tx_req;
  logic rx_evt;
  logic tx_evt;
  logic rx_sf;
  logic tx_sf;
  logic rx_ch_e;
  logic tx_ch_e;
  logic emu_halt = 1'b0;
  logic bus_pending = 1'b0;
  logic clk_stop_req = 1'b0;
  logic clk_stop_ack;
  logic idle;
  logic watch = 1'b0;
  logic [7:0] rx_last = 8'h00;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_valid = 0;
  int n_evt = 0;
  int n_req = 0;
  int n_drive = 0;
  int n_bad = 0;
  int n_tevt = 0;
  int n_sf = 0;
  int n_ch = 0;
  int n_tch = 0;
  int k;
  // last two rows: locked emulation word, unmapped address
  tpr_row_t rows [7] = '{
    '{tpr_pkg::OFF_EMU, 32'h00030003, 32'h00030003},
    '{tpr_pkg::OFF_SIU_CTL, 32'h00000004, 32'h00000004},
    '{tpr_pkg::OFF_TX_CH, 32'h00000001, 32'h00000001},
    '{tpr_pkg::OFF_RX_CH, 32'h00000001, 32'h00000001},
    '{tpr_pkg::OFF_PATH_CTL, 32'h00000001, 32'h00000001},
    '{tpr_pkg::OFF_EMU, 32'h00000000, 32'h00030003},
    '{12'h010, 32'hFFFFFFFF, 32'h00000000}
  };

  tpr_port_ctl #(.N_CH(1)) i_tpr_port_ctl (
    .mclk(mclk), .resetn(resetn), .ce(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link_sclk(sclk), .link_fsync(fsync), .rx_lane_pin(sdata),
    .tx_lane_pin_o(pin), .tx_lane_pin_oe_n(pin_oe_n),
    .rx_parallel_out(rx_byte), .rx_byte_valid(rx_valid), .tx_parallel_in(tx_byte), .tx_byte_req(tx_req),
    .rx_frame_evt(rx_evt), .tx_frame_evt(tx_evt), .rx_sf_evt(rx_sf), .tx_sf_evt(tx_sf),
    .rx_ch_evt(rx_ch_e), .tx_ch_evt(tx_ch_e),
    .emu_halt(emu_halt), .bus_pending(bus_pending), .clk_stop_req(clk_stop_req),
    .clk_stop_ack(clk_stop_ack), .idle_indicator_out(idle)
  );

  tpr_framer i_tpr_framer (.sclk(sclk), .fsync(fsync), .sdata(sdata));

  always #4 mclk = ~mclk;

  // event counters, pin watch and hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (rx_valid === 1'b1)
    begin
      n_valid++;
      rx_last = rx_byte;
    end
    if (rx_evt === 1'b1)
      n_evt++;
    if (tx_evt === 1'b1)
      n_tevt++;
    if (rx_sf === 1'b1)
      n_sf++;
    if (tx_sf === 1'b1)
      n_sf++;
    if (rx_ch_e === 1'b1)
      n_ch++;
    if (tx_ch_e === 1'b1)
      n_tch++;
    if (tx_req === 1'b1)
      n_req++;
    if (pin_oe_n !== 1'b1)
      n_drive++;
    if (watch && (pin !== 1'b1 || pin_oe_n !== 1'b0))
      n_bad++;
    if (cycles == 8000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] w);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= w;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata === e, "register read");
  endtask : rd_chk

  task automatic wait_idle(input logic v);
    int n;
    for (n = 0; n < 40 && idle !== v; n++)
      @(posedge mclk);
    @(negedge mclk);
    chk(idle === v, "idle indicator");
  endtask : wait_idle

  // lets the two-flop link sampling land
  task automatic settle();
    repeat (10) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic clr();
    @(negedge mclk);
    n_valid = 0;
    n_evt = 0;
    n_req = 0;
    n_drive = 0;
    n_bad = 0;
    n_tevt = 0;
    n_sf = 0;
    n_ch = 0;
    n_tch = 0;
  endtask : clr

  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    wait_idle(1'b1);
    @(posedge mclk);
    clk_stop_req <= 1'b1;
    rd_chk(tpr_pkg::OFF_EMU, 32'h00000001);
    chk(clk_stop_ack === 1'b1, "ack while idle");
    rd_chk(tpr_pkg::OFF_RESET, 32'h00000000);
    rd_chk(tpr_pkg::OFF_SIU_CTL, 32'h00000000);
    for (k = 0; k < 7; k++)
    begin
      wr_reg(rows[k].a, rows[k].w);
      rd_chk(rows[k].a, rows[k].r);
    end
    chk(idle === 1'b0 && clk_stop_ack === 1'b0, "active block idle");
    wr_reg(tpr_pkg::OFF_PATH_CTL, 32'h00000000);
    rd_chk(tpr_pkg::OFF_TX_CH, 32'h00000001);
    wr_reg(tpr_pkg::OFF_RESET, 32'h00000002);
    rd_chk(tpr_pkg::OFF_RX_CH, 32'h00000000);
    rd_chk(tpr_pkg::OFF_TX_CH, 32'h00000000);
    rd_chk(tpr_pkg::OFF_SIU_CTL, 32'h00000004);
    wait_idle(1'b1);
    @(posedge mclk);
    bus_pending <= 1'b1;
    wait_idle(1'b0);
    chk(clk_stop_ack === 1'b0, "ack while pending");
    @(posedge mclk);
    bus_pending <= 1'b0;
    // serial unit reset
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000005);
    wr_reg(tpr_pkg::OFF_RESET, 32'h00000001);
    rd_chk(tpr_pkg::OFF_RESET, 32'h00000001);
    repeat (6) @(posedge mclk);
    rd_chk(tpr_pkg::OFF_RESET, 32'h00000000);
    rd_chk(tpr_pkg::OFF_SIU_CTL, 32'h00000000);
    rd_chk(tpr_pkg::OFF_EMU, 32'h00000001);
    wr_reg(tpr_pkg::OFF_RESET, 32'h00000000);
    rd_chk(tpr_pkg::OFF_RESET, 32'h00000000);
    // receive with halt ignored
    @(posedge mclk);
    emu_halt <= 1'b1;
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000001);
    clr();
    i_tpr_framer.send_frames(8'hA5, 2);
    settle();
    chk(n_valid === 2 && rx_last === 8'hA5, "received bytes");
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000000);
    clr();
    i_tpr_framer.send_frames(8'hA5, 1);
    settle();
    chk(n_valid === 0 && n_evt === 0, "receive events while off");
    // halt honoured: one full frame, then the next-frame event and stop
    wr_reg(tpr_pkg::OFF_EMU, 32'h00000000);
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000001);
    clr();
    i_tpr_framer.send_frames(8'hA5, 3);
    settle();
    chk(n_evt === 2 && n_valid === 1, "halt at frame end");
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000000);
    @(posedge mclk);
    emu_halt <= 1'b0;
    // transmit start-up, disabled state drives high
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000008);
    settle();
    clr();
    watch = 1'b1;
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h0000000A);
    // keep link pin changes off the sampling edge
    @(negedge mclk);
    i_tpr_framer.send_frames(8'h00, 1);
    settle();
    watch = 1'b0;
    chk(n_bad === 0 && n_req === 0 && n_tevt === 1, "held before second sync");
    i_tpr_framer.send_frames(8'h00, 2);
    settle();
    chk(n_req > 0, "transmit started");
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000008);
    settle();
    clr();
    watch = 1'b1;
    i_tpr_framer.send_frames(8'h00, 1);
    settle();
    watch = 1'b0;
    chk(n_bad === 0 && n_req === 0 && n_tevt === 0, "transmit after disable");
    // inner loopback keeps the pin released
    wr_reg(tpr_pkg::OFF_EMU, 32'h00010001);
    wr_reg(tpr_pkg::OFF_RX_CH, 32'h00000001);
    wr_reg(tpr_pkg::OFF_PATH_CTL, 32'h00000001);
    wr_reg(tpr_pkg::OFF_SIU_CTL, 32'h00000003);
    clr();
    i_tpr_framer.send_frames(8'hFF, 4);
    settle();
    chk(n_drive === 0 && n_valid > 0 && rx_last !== 8'hFF, "inner loopback");
    chk(n_evt === 4 && n_tevt === 4 && n_sf === 2, "frame and superframe events");
    chk(n_ch === 4 && n_tch === 0, "channel events");
    close_out();
  end
endmodule : tpr_port_ctl_test

// File: verilog/tpr_pkg.sv
// constants and types of the port reset, emulation and loopback block
package tpr_pkg;
  localparam int ADDR_W = 12;
  // register offsets
  localparam logic [11:0] OFF_EMU = 12'h004;
  localparam logic [11:0] OFF_RESET = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_SIU_CTL = 12'h080;
  localparam logic [11:0] OFF_PATH_CTL = 12'h100;
  localparam logic [11:0] OFF_TX_CH = 12'h800;
  localparam logic [11:0] OFF_RX_CH = 12'hC00;
  // field positions
  localparam int EMU_IGN_BIT = 0;
  localparam int EMU_SCOPE_BIT = 1;
  localparam int EMU_LB_EN_BIT = 16;
  localparam int EMU_LB_TYPE_BIT = 17;
  localparam int RST_SIU_BIT = 0;
  localparam int RST_PATH_BIT = 1;
  localparam int CTL_RX_EN_BIT = 0;
  localparam int CTL_TX_EN_BIT = 1;
  localparam int CTL_DIS_LSB = 2;
  localparam int PATH_EN_BIT = 0;
  // values after reset and disabled-pin encodings
  localparam logic EMU_IGN_RST = 1'b1;
  localparam logic [1:0] DIS_HIZ = 2'h0;
  localparam logic [1:0] DIS_LOW = 2'h1;
  localparam logic [1:0] DIS_HIGH = 2'h2;
  // cycle, frame and bit counts
  localparam logic [2:0] RST_CYCLES = 3'h4;
  localparam logic [7:0] SF_ROLL = 8'h03;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  typedef enum logic [2:0] {RX_OFF, RX_ARM, RX_WAIT, RX_RUN, RX_HALT} tpr_rx_state_t;
  typedef enum logic [2:0] {TX_OFF, TX_ARM, TX_WAIT1, TX_WAIT2, TX_RUN, TX_HALT} tpr_tx_state_t;
endpackage : tpr_pkg

// File: verilog/tpr_port_ctl.sv
// reset, idle, emulation halt and loopback control of the serial port
`timescale 1ns/100ps
module tpr_port_ctl #(
  parameter int N_CH = 1
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // register port
  input wire logic [tpr_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // link pins
  input wire logic link_sclk,
  input wire logic link_fsync,
  input wire logic rx_lane_pin,
  output logic tx_lane_pin_o,
  output logic tx_lane_pin_oe_n,
  // parallel data
  output logic [7:0] rx_parallel_out,
  output logic rx_byte_valid,
  input wire logic [7:0] tx_parallel_in,
  output logic tx_byte_req,
  // events
  output logic rx_frame_evt,
  output logic tx_frame_evt,
  output logic rx_sf_evt,
  output logic tx_sf_evt,
  output logic [N_CH-1:0] rx_ch_evt,
  output logic [N_CH-1:0] tx_ch_evt,
  // emulation and power
  input wire logic emu_halt,
  input wire logic bus_pending,
  input wire logic clk_stop_req,
  output logic clk_stop_ack,
  output logic idle_indicator_out
);
  if (N_CH < 1 || N_CH > 32)
  begin : g_bad_n_ch
    $error("tpr_port_ctl: N_CH must be 1 to 32");
  end

  logic rst_m, rst_n;
  logic sclk_m, sclk_s, sclk_d, fs_m, fs_s, fs_prev, rxd_m, rxd_s, halt_m, halt_s;
  logic rx_en, tx_en, path_en, siu_busy;
  logic [1:0] tx_dis;
  logic ignore_halt, halt_scope, lb_en, lb_type;
  logic [2:0] rst_cnt;
  logic [N_CH-1:0] tx_ch, rx_ch;
  tpr_pkg::tpr_rx_state_t rx_state;
  tpr_pkg::tpr_tx_state_t tx_state;
  logic [7:0] rx_sh, tx_sh, rx_sf_cnt, tx_sf_cnt;
  logic [2:0] rx_cnt, tx_cnt;

  // reset release through two flops
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end

  // pin synchronisers, first stage read only by second
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      {sclk_m, sclk_s, sclk_d, fs_m, fs_s, rxd_m, rxd_s, halt_m, halt_s} <= 9'h000;
    end
    else if (ce)
    begin
      sclk_m <= link_sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      fs_m <= link_fsync;
      fs_s <= fs_m;
      rxd_m <= rx_lane_pin;
      rxd_s <= rxd_m;
      halt_m <= emu_halt;
      halt_s <= halt_m;
    end

  logic sclk_rise, fs_start, inner, line, halt_rx, halt_tx, xfer_halt, rx_bit;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign fs_start = sclk_rise & fs_s & ~fs_prev;
  assign inner = lb_en & ~lb_type;
  assign line = lb_en & lb_type;
  assign halt_rx = halt_s & ~ignore_halt;
  assign halt_tx = halt_rx & ~halt_scope;
  assign xfer_halt = (rx_state == tpr_pkg::RX_HALT) | (tx_state == tpr_pkg::TX_HALT);
  assign rx_bit = inner ? tx_sh[7] : rxd_s;

  // frame sync history, sampled on serial clock edges only
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      fs_prev <= 1'b0;
    else if (ce && sclk_rise)
      fs_prev <= fs_s;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      siu_busy <= 1'b0;
      rst_cnt <= 3'h0;
    end
    else if (ce)
    begin
      if (wr && addr == tpr_pkg::OFF_RESET && wdata[tpr_pkg::RST_SIU_BIT])
      begin
        siu_busy <= 1'b1;
        rst_cnt <= tpr_pkg::RST_CYCLES;
      end
      else if (siu_busy)
      begin
        rst_cnt <= rst_cnt - 3'h1;
        if (rst_cnt == 3'h1)
          siu_busy <= 1'b0;
      end
    end

  // serial unit configuration
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      tx_dis <= tpr_pkg::DIS_HIZ;
      ignore_halt <= tpr_pkg::EMU_IGN_RST;
      halt_scope <= 1'b0;
      lb_en <= 1'b0;
      lb_type <= 1'b0;
    end
    else if (ce)
    begin
      if (siu_busy)
      begin
        rx_en <= 1'b0;
        tx_en <= 1'b0;
        tx_dis <= tpr_pkg::DIS_HIZ;
        ignore_halt <= tpr_pkg::EMU_IGN_RST;
        halt_scope <= 1'b0;
        lb_en <= 1'b0;
        lb_type <= 1'b0;
      end
      else if (wr)
      begin
        if (addr == tpr_pkg::OFF_SIU_CTL)
        begin
          rx_en <= wdata[tpr_pkg::CTL_RX_EN_BIT];
          tx_en <= wdata[tpr_pkg::CTL_TX_EN_BIT];
          tx_dis <= wdata[tpr_pkg::CTL_DIS_LSB +: 2];
        end
        if (addr == tpr_pkg::OFF_EMU && !path_en)
        begin
          ignore_halt <= wdata[tpr_pkg::EMU_IGN_BIT];
          halt_scope <= wdata[tpr_pkg::EMU_SCOPE_BIT];
          lb_en <= wdata[tpr_pkg::EMU_LB_EN_BIT];
          lb_type <= wdata[tpr_pkg::EMU_LB_TYPE_BIT];
        end
      end
    end

  // transfer path and channel enables
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      path_en <= 1'b0;
      tx_ch <= '0;
      rx_ch <= '0;
    end
    else if (ce && wr)
    begin
      if (addr == tpr_pkg::OFF_RESET && wdata[tpr_pkg::RST_PATH_BIT])
      begin
        path_en <= 1'b0;
        tx_ch <= '0;
        rx_ch <= '0;
      end
      else if (addr == tpr_pkg::OFF_PATH_CTL)
        path_en <= wdata[tpr_pkg::PATH_EN_BIT];
      else if (addr == tpr_pkg::OFF_TX_CH)
        tx_ch <= wdata[N_CH-1:0];
      else if (addr == tpr_pkg::OFF_RX_CH)
        rx_ch <= wdata[N_CH-1:0];
    end

  // receive sequencing
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rx_state <= tpr_pkg::RX_OFF;
    else if (ce)
    begin
      if (!rx_en || siu_busy)
        rx_state <= tpr_pkg::RX_OFF;
      else if (sclk_rise)
        case (rx_state)
          // first sample after enable may already be the inactive one
          tpr_pkg::RX_OFF: rx_state <= fs_s ? tpr_pkg::RX_ARM : tpr_pkg::RX_WAIT;
          tpr_pkg::RX_ARM: if (!fs_s) rx_state <= tpr_pkg::RX_WAIT;
          tpr_pkg::RX_WAIT: if (fs_start) rx_state <= tpr_pkg::RX_RUN;
          tpr_pkg::RX_RUN: if (fs_start && halt_rx) rx_state <= tpr_pkg::RX_HALT;
          tpr_pkg::RX_HALT: if (!halt_rx) rx_state <= tpr_pkg::RX_ARM;
          default: rx_state <= tpr_pkg::RX_OFF;
        endcase
    end

  logic rx_take, rx_evt_c;
  assign rx_evt_c = fs_start & rx_en & ~siu_busy &
                    (rx_state == tpr_pkg::RX_WAIT || rx_state == tpr_pkg::RX_RUN);
  assign rx_take = rx_evt_c & ~(rx_state == tpr_pkg::RX_RUN && halt_rx) |
                   (sclk_rise & ~fs_start & rx_state == tpr_pkg::RX_RUN);

  // receive shift, data and counters
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      rx_sh <= 8'h00;
      rx_cnt <= 3'h0;
      rx_parallel_out <= 8'h00;
      rx_byte_valid <= 1'b0;
    end
    else if (ce)
    begin
      rx_byte_valid <= 1'b0;
      if (!rx_en || siu_busy)
      begin
        rx_sh <= 8'h00;
        rx_cnt <= 3'h0;
        rx_parallel_out <= 8'h00;
      end
      else if (rx_take)
      begin
        rx_sh <= {rx_sh[6:0], rx_bit};
        rx_cnt <= fs_start ? 3'h1 : rx_cnt + 3'h1;
        if (!fs_start && rx_cnt == tpr_pkg::BYTE_LAST)
        begin
          rx_parallel_out <= {rx_sh[6:0], rx_bit};
          rx_byte_valid <= 1'b1;
        end
      end
    end

  // transmit sequencing
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      tx_state <= tpr_pkg::TX_OFF;
    else if (ce)
    begin
      if (!tx_en || siu_busy)
        tx_state <= tpr_pkg::TX_OFF;
      else if (sclk_rise)
        case (tx_state)
          tpr_pkg::TX_OFF: tx_state <= fs_s ? tpr_pkg::TX_ARM : tpr_pkg::TX_WAIT1;
          tpr_pkg::TX_ARM: if (!fs_s) tx_state <= tpr_pkg::TX_WAIT1;
          tpr_pkg::TX_WAIT1: if (fs_start) tx_state <= tpr_pkg::TX_WAIT2;
          tpr_pkg::TX_WAIT2: if (fs_start) tx_state <= tpr_pkg::TX_RUN;
          tpr_pkg::TX_RUN: if (fs_start && halt_tx) tx_state <= tpr_pkg::TX_HALT;
          tpr_pkg::TX_HALT: if (!halt_tx) tx_state <= tpr_pkg::TX_ARM;
          default: tx_state <= tpr_pkg::TX_OFF;
        endcase
    end

  logic tx_evt_c, tx_go, tx_load;
  logic [7:0] tx_src;
  assign tx_evt_c = fs_start & tx_en & ~siu_busy & (tx_state == tpr_pkg::TX_WAIT1 ||
                    tx_state == tpr_pkg::TX_WAIT2 || tx_state == tpr_pkg::TX_RUN);
  assign tx_go = (fs_start & tx_state == tpr_pkg::TX_WAIT2) |
                 (sclk_rise & tx_state == tpr_pkg::TX_RUN & ~(fs_start & halt_tx));
  assign tx_load = fs_start | (tx_cnt == 3'h0);
  assign tx_src = line ? rx_parallel_out : tx_parallel_in;

  // transmit shift, counters; halted scope 1 resends unchanged input
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      tx_sh <= 8'h00;
      tx_cnt <= 3'h0;
      tx_byte_req <= 1'b0;
    end
    else if (ce)
    begin
      tx_byte_req <= 1'b0;
      if (!tx_en || siu_busy)
      begin
        tx_sh <= 8'h00;
        tx_cnt <= 3'h0;
      end
      else if (tx_go && tx_en)
      begin
        tx_sh <= tx_load ? tx_src : {tx_sh[6:0], 1'b0};
        tx_cnt <= tx_load ? 3'h1 : tx_cnt + 3'h1;
        tx_byte_req <= tx_load;
      end
    end

  // pin drive; disabled state also covers the gap between syncs
  logic drive_data;
  assign drive_data = (tx_state == tpr_pkg::TX_RUN) & tx_en & ~siu_busy & ~inner;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      tx_lane_pin_o <= 1'b0;
      tx_lane_pin_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      tx_lane_pin_o <= drive_data ? tx_sh[7] : (tx_dis == tpr_pkg::DIS_HIGH);
      tx_lane_pin_oe_n <= inner | (~drive_data & (tx_dis == tpr_pkg::DIS_HIZ));
    end

  // frame and superframe events
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      rx_frame_evt <= 1'b0;
      tx_frame_evt <= 1'b0;
      rx_sf_evt <= 1'b0;
      tx_sf_evt <= 1'b0;
      rx_sf_cnt <= 8'h00;
      tx_sf_cnt <= 8'h00;
    end
    else if (ce)
    begin
      rx_frame_evt <= rx_evt_c;
      tx_frame_evt <= tx_evt_c;
      rx_sf_evt <= rx_evt_c & (rx_sf_cnt == tpr_pkg::SF_ROLL);
      tx_sf_evt <= tx_evt_c & (tx_sf_cnt == tpr_pkg::SF_ROLL);
      if (!rx_en || siu_busy)
        rx_sf_cnt <= 8'h00;
      else if (rx_evt_c)
        rx_sf_cnt <= (rx_sf_cnt == tpr_pkg::SF_ROLL) ? 8'h00 : rx_sf_cnt + 8'h01;
      if (!tx_en || siu_busy)
        tx_sf_cnt <= 8'h00;
      else if (tx_evt_c)
        tx_sf_cnt <= (tx_sf_cnt == tpr_pkg::SF_ROLL) ? 8'h00 : tx_sf_cnt + 8'h01;
    end

  // channel events; halted transfer logic gates both directions
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      rx_ch_evt <= '0;
      tx_ch_evt <= '0;
    end
    else if (ce)
    begin
      rx_ch_evt <= {N_CH{rx_evt_c & path_en & ~xfer_halt}} & rx_ch;
      tx_ch_evt <= {N_CH{tx_evt_c & path_en & ~xfer_halt}} & tx_ch;
    end

  logic idle_c;
  assign idle_c = ~rx_en & ~tx_en & ~path_en & ~(|tx_ch) & ~(|rx_ch) & ~bus_pending;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      idle_indicator_out <= 1'b0;
    else if (ce)
      idle_indicator_out <= idle_c;

  assign clk_stop_ack = clk_stop_req & idle_indicator_out;

  // register reads, unmapped offsets read zero
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (ce)
    begin
      rdata <= 32'h0000_0000;
      if (rd)
        case (addr)
          tpr_pkg::OFF_EMU: rdata <= {14'h0000, lb_type, lb_en, 14'h0000, halt_scope, ignore_halt};
          tpr_pkg::OFF_RESET: rdata <= {31'h0000_0000, siu_busy};
          tpr_pkg::OFF_STATUS: rdata <= {26'h000_0000, siu_busy, tx_state == tpr_pkg::TX_HALT,
            rx_state == tpr_pkg::RX_HALT, tx_state == tpr_pkg::TX_RUN, rx_state == tpr_pkg::RX_RUN, idle_c};
          tpr_pkg::OFF_SIU_CTL: rdata <= {28'h000_0000, tx_dis, tx_en, rx_en};
          tpr_pkg::OFF_PATH_CTL: rdata <= {31'h0000_0000, path_en};
          tpr_pkg::OFF_TX_CH: rdata <= 32'(tx_ch);
          tpr_pkg::OFF_RX_CH: rdata <= 32'(rx_ch);
          default: rdata <= 32'h0000_0000;
        endcase
    end

  property p_rst_busy;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr && addr == tpr_pkg::OFF_RESET && wdata[0]) |=> siu_busy ##[1:8] !siu_busy;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("reset bit did not complete");

  property p_rst_regs;
    @(posedge mclk) disable iff (!rst_n)
    $rose(siu_busy) && ce |=> !rx_en && !tx_en && ignore_halt && !lb_en;
  endproperty
  a_rst_regs: assert property (p_rst_regs) else $error("serial unit reset left config");

  property p_rx_quiet;
    @(posedge mclk) disable iff (!rst_n)
    !rx_en && !$past(rx_en) |-> !rx_frame_evt && !rx_byte_valid && !rx_sf_evt;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("event from disabled receive");

  property p_tx_clear;
    @(posedge mclk) disable iff (!rst_n)
    ce && !tx_en |=> tx_state == tpr_pkg::TX_OFF && tx_sh == 8'h00 && tx_cnt == 3'h0;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit not cleared");

  property p_rx_arm;
    @(posedge mclk) disable iff (!rst_n)
    ce && rx_en && rx_state == tpr_pkg::RX_ARM |=> rx_state != tpr_pkg::RX_RUN;
  endproperty
  a_rx_arm: assert property (p_rx_arm) else $error("receive started without inactive sync");

  property p_tx_two_syncs;
    @(posedge mclk) disable iff (!rst_n)
    ce && tx_state == tpr_pkg::TX_WAIT1 |=> tx_state != tpr_pkg::TX_RUN;
  endproperty
  a_tx_two_syncs: assert property (p_tx_two_syncs) else $error("transmit began at first sync");

  property p_path_rst;
    @(posedge mclk) disable iff (!rst_n)
    ce && wr && addr == tpr_pkg::OFF_RESET && wdata[1] |=> !path_en && tx_ch == '0 && rx_ch == '0;
  endproperty
  a_path_rst: assert property (p_path_rst) else $error("path reset left channels on");

  property p_idle;
    @(posedge mclk) disable iff (!rst_n)
    idle_indicator_out |-> !$past(rx_en) && !$past(tx_en) && !$past(path_en) && !$past(bus_pending) &&
      $past(tx_ch) == '0 && $past(rx_ch) == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle while active");

  property p_ack;
    @(posedge mclk) disable iff (!rst_n)
    clk_stop_ack |-> clk_stop_req && !$past(rx_en) && !$past(tx_en) && !$past(path_en) &&
      !$past(bus_pending);
  endproperty
  a_ack: assert property (p_ack) else $error("clock stop acknowledged while active");

  property p_emu_lock;
    @(posedge mclk) disable iff (!rst_n)
    ce && path_en && !siu_busy && wr && addr == tpr_pkg::OFF_EMU |=>
      $stable({ignore_halt, lb_en, lb_type, halt_scope});
  endproperty
  a_emu_lock: assert property (p_emu_lock) else $error("locked field changed");

  property p_inner_pins;
    @(posedge mclk) disable iff (!rst_n)
    ce && inner && $past(inner) |=> tx_lane_pin_oe_n;
  endproperty
  a_inner_pins: assert property (p_inner_pins) else $error("pin driven in inner loopback");
endmodule : tpr_port_ctl
